// ### design/spn_ide_decode.v
`timescale 1ns/10ps
`include "spn_map.vh"

module spn_ide_decode (
  // Address and enables
  input wire [15:0] addr,
  input wire [3:0] range_en,
  input wire fast_pri_en,
  input wire fast_sec_en,
  // Decode results, active high
  output reg task_file_hit,
  output reg control_hit,
  output reg fast_start,
  output reg [4:0] periph_hit
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  function tf_hit;
    input [15:0] a;
    input [15:0] base;
    begin
      tf_hit = (a[15:3] == base[15:3]);
    end
  endfunction

  function cb_hit;
    input [15:0] a;
    input [15:0] base;
    begin
      cb_hit = (a[15:1] == base[15:1]);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  always @* begin
    task_file_hit = (range_en[0] && tf_hit(addr, `SPN_IDE1_TF)) ||
                    (range_en[1] && tf_hit(addr, `SPN_IDE2_TF)) ||
                    (range_en[2] && tf_hit(addr, `SPN_IDE3_TF)) ||
                    (range_en[3] && tf_hit(addr, `SPN_IDE4_TF));
    control_hit = (range_en[0] && cb_hit(addr, `SPN_IDE1_CB)) ||
                  (range_en[1] && cb_hit(addr, `SPN_IDE2_CB)) ||
                  (range_en[2] && cb_hit(addr, `SPN_IDE3_CB)) ||
                  (range_en[3] && cb_hit(addr, `SPN_IDE4_CB));
    // Any access width lands on the base word, so only the base address starts it.
    fast_start = (fast_pri_en && addr == `SPN_IDE1_TF) ||
                 (fast_sec_en && addr == `SPN_IDE2_TF);
    // Bit 0 keyboard, 1 serial, 2 parallel, 3 floppy, 4 video.
    periph_hit[0] = (addr == `SPN_KBD_DATA) || (addr == `SPN_KBD_CMD);
    periph_hit[1] = in_range(addr, `SPN_SER4_LO, `SPN_SER4_HI) || in_range(addr, `SPN_SER2_LO, `SPN_SER2_HI) ||
                    in_range(addr, `SPN_SER3_LO, `SPN_SER3_HI) || in_range(addr, `SPN_SER1_LO, `SPN_SER1_HI);
    periph_hit[2] = in_range(addr, `SPN_PAR3_LO, `SPN_PAR3_HI) || in_range(addr, `SPN_PAR2_LO, `SPN_PAR2_HI) ||
                    in_range(addr, `SPN_PAR1_LO, `SPN_PAR1_HI);
    periph_hit[3] = in_range(addr, `SPN_FLP2_LO, `SPN_FLP2_HI) || in_range(addr, `SPN_FLP1_LO, `SPN_FLP1_HI);
    periph_hit[4] = in_range(addr, `SPN_VID_MONO_LO, `SPN_VID_MONO_HI) ||
                    in_range(addr, `SPN_VID_COLOR_LO, `SPN_VID_COLOR_HI);
  end

endmodule // spn_ide_decode

// ### design/spn_map.vh
`ifndef SPN_MAP_VH
`define SPN_MAP_VH

// ----------------------------------------------------------------------------
// I/O port addresses and the RTC shadow configuration index
// ----------------------------------------------------------------------------
`define SPN_PORT_SYS_CTRL 16'h0061
`define SPN_PORT_RTC_INDEX 16'h0070
`define SPN_PORT_FAST_RESET 16'h0092
`define SPN_CFG_RTC_SHADOW 8'h96

// ----------------------------------------------------------------------------
// System control/status port fields
// ----------------------------------------------------------------------------
`define SPN_SC_SECOND_TIMER_GATE_BIT 0
`define SPN_SC_SPKR_DATA 1
`define SPN_SC_PAR_EN_N 2
`define SPN_SC_CHCK_EN_N 3
`define SPN_SC_REFRESH 4
`define SPN_SC_TMR2_OUT 5
`define SPN_SC_CHCK 6
`define SPN_SC_PARITY 7
`define SPN_SC_RESET 4'h0

// ----------------------------------------------------------------------------
// RTC index port and fast reset port fields
// ----------------------------------------------------------------------------
`define SPN_RTC_NMI_MASK 7
`define SPN_RTC_RESET 8'h00
`define SPN_FR_RESET_BIT 0
`define SPN_FR_A20_BIT 1
`define SPN_FR_RESET 2'h0

// ----------------------------------------------------------------------------
// IDE ranges: task-file base and control-block base of each range
// ----------------------------------------------------------------------------
`define SPN_IDE1_TF 16'h01F0
`define SPN_IDE1_CB 16'h03F6
`define SPN_IDE2_TF 16'h0170
`define SPN_IDE2_CB 16'h0376
`define SPN_IDE3_TF 16'h05F0
`define SPN_IDE3_CB 16'h07F6
`define SPN_IDE4_TF 16'h0570
`define SPN_IDE4_CB 16'h0776

// ----------------------------------------------------------------------------
// Peripheral ranges watched for events, never claimed
// ----------------------------------------------------------------------------
`define SPN_KBD_DATA 16'h0060
`define SPN_KBD_CMD 16'h0064
`define SPN_SER4_LO 16'h02E8
`define SPN_SER4_HI 16'h02EF
`define SPN_SER2_LO 16'h02F8
`define SPN_SER2_HI 16'h02FF
`define SPN_SER3_LO 16'h03E8
`define SPN_SER3_HI 16'h03EF
`define SPN_SER1_LO 16'h03F8
`define SPN_SER1_HI 16'h03FF
`define SPN_PAR3_LO 16'h0278
`define SPN_PAR3_HI 16'h027F
`define SPN_PAR2_LO 16'h0378
`define SPN_PAR2_HI 16'h037F
`define SPN_PAR1_LO 16'h03BC
`define SPN_PAR1_HI 16'h03BE
`define SPN_FLP2_LO 16'h0370
`define SPN_FLP2_HI 16'h0375
`define SPN_FLP1_LO 16'h03F0
`define SPN_FLP1_HI 16'h03F5
`define SPN_VID_MONO_LO 16'h03B0
`define SPN_VID_MONO_HI 16'h03BB
`define SPN_VID_COLOR_LO 16'h03C0
`define SPN_VID_COLOR_HI 16'h03DF

`endif

// ### design/spn_port_decode.v
`timescale 1ns/10ps
`include "spn_map.vh"

module spn_port_decode (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Host I/O access, one-cycle strobes
  input wire [15:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_rd,
  input wire io_wr,
  output reg [7:0] io_rdata,
  output reg io_claim,
  // Configuration index read
  input wire [7:0] cfg_index,
  output reg [7:0] cfg_rdata,
  // Timer, speaker and error sources
  input wire timer2_out,
  input wire refresh_toggle,
  input wire channel_check_n,
  input wire parity_error,
  input wire nmi_ext,
  output reg second_timer_gate_bit,
  output reg speaker_out,
  output reg nmi_out,
  // Fast reset and gate
  input wire smi_redirect,
  output reg cpu_reset_pulse,
  output reg system_management_interrupt,
  output reg address_line_20_gate,
  // IDE
  input wire [3:0] ide_range_en,
  input wire fast_ide_pri_en,
  input wire fast_ide_sec_en,
  output reg ide_task_file_select_n,
  output reg ide_control_block_select_n,
  output reg ide_start,
  // Peripheral events
  output reg [4:0] periph_event
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [3:0] sys_ctrl_reg;
  reg chck_latch_reg;
  reg parity_latch_reg;
  reg [7:0] rtc_index_reg;
  reg [1:0] fast_reset_reg;
  reg [3:0] sys_ctrl_next;
  reg chck_latch_next;
  reg parity_latch_next;
  reg [7:0] rtc_index_next;
  reg [1:0] fast_reset_next;

  // --------------------------------------------------------------------------
  // Next values of the registered outputs
  // --------------------------------------------------------------------------
  reg [7:0] io_rdata_next;
  reg io_claim_next;
  reg [7:0] cfg_rdata_next;
  reg second_timer_gate_bit_next;
  reg speaker_out_next;
  reg nmi_out_next;
  reg cpu_reset_pulse_next;
  reg system_management_interrupt_next;
  reg address_line_20_gate_next;
  reg ide_task_file_select_n_next;
  reg ide_control_block_select_n_next;
  reg ide_start_next;
  reg [4:0] periph_event_next;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  wire access;
  wire hit_sc;
  wire hit_rtc;
  wire hit_fr;
  wire tf_hit;
  wire cb_hit;
  wire start_hit;
  wire [4:0] periph_hit;
  wire [7:0] sc_read_word;
  wire t2_status;
  wire fr_rise;
  wire nmi_sources;

  // Ports are decoded on all 16 address bits, so aliases higher up stay unclaimed.
  function port_is;
    input [15:0] a;
    input [15:0] port;
    begin
      port_is = (a == port);
    end
  endfunction

  // The IDE selects are active low and only follow a strobed access.
  function select_n;
    input strobe;
    input hit;
    begin
      select_n = ~(strobe & hit);
    end
  endfunction

  // Reads and writes decode alike; only the claim, the read data and the write paths tell them apart.
  assign access = io_rd | io_wr;
  assign hit_sc = port_is(io_addr, `SPN_PORT_SYS_CTRL);
  assign hit_rtc = port_is(io_addr, `SPN_PORT_RTC_INDEX);
  assign hit_fr = port_is(io_addr, `SPN_PORT_FAST_RESET);

  // A closed gate stops the timer and its status reads as 1.
  assign t2_status = sys_ctrl_reg[`SPN_SC_SECOND_TIMER_GATE_BIT] ? timer2_out : 1'b1;
  assign sc_read_word = {parity_latch_reg, chck_latch_reg, t2_status, refresh_toggle, sys_ctrl_reg};
  // The stored bit is compared before it is updated, so rewriting a 1 gives no pulse.
  assign fr_rise = io_wr && hit_fr && io_wdata[`SPN_FR_RESET_BIT] && !fast_reset_reg[`SPN_FR_RESET_BIT];
  assign nmi_sources = chck_latch_reg | parity_latch_reg | nmi_ext;

  // The range decoder is pure logic; every hit is qualified by a strobe here.
  spn_ide_decode u_ide (
    .addr(io_addr),
    .range_en(ide_range_en),
    .fast_pri_en(fast_ide_pri_en),
    .fast_sec_en(fast_ide_sec_en),
    .task_file_hit(tf_hit),
    .control_hit(cb_hit),
    .fast_start(start_hit),
    .periph_hit(periph_hit)
  );

  // --------------------------------------------------------------------------
  // Writable ports
  // --------------------------------------------------------------------------
  always @* begin
    sys_ctrl_next = sys_ctrl_reg;
    rtc_index_next = rtc_index_reg;
    fast_reset_next = fast_reset_reg;
    if (io_wr && hit_sc) begin
      // Bits 4 to 7 are status, so a write leaves them alone.
      sys_ctrl_next = io_wdata[3:0];
    end
    if (io_wr && hit_rtc) begin
      rtc_index_next = io_wdata;
    end
    if (io_wr && hit_fr) begin
      fast_reset_next = io_wdata[1:0];
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sys_ctrl_reg <= `SPN_SC_RESET;
      rtc_index_reg <= `SPN_RTC_RESET;
      fast_reset_reg <= `SPN_FR_RESET;
    end else begin
      sys_ctrl_reg <= sys_ctrl_next;
      rtc_index_reg <= rtc_index_next;
      fast_reset_reg <= fast_reset_next;
    end
  end

  // --------------------------------------------------------------------------
  // Error latches
  // --------------------------------------------------------------------------
  // An enable bit at 1 holds its latch clear; a source can only set it while enabled,
  // so a set and a clear never meet in one cycle.
  always @* begin
    chck_latch_next = chck_latch_reg;
    parity_latch_next = parity_latch_reg;
    if (sys_ctrl_reg[`SPN_SC_CHCK_EN_N]) begin
      chck_latch_next = 1'b0;
    end else if (!channel_check_n) begin
      chck_latch_next = 1'b1;
    end
    if (sys_ctrl_reg[`SPN_SC_PAR_EN_N]) begin
      parity_latch_next = 1'b0;
    end else if (parity_error) begin
      parity_latch_next = 1'b1;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      chck_latch_reg <= 1'b0;
      parity_latch_reg <= 1'b0;
    end else begin
      chck_latch_reg <= chck_latch_next;
      parity_latch_reg <= parity_latch_next;
    end
  end

  // --------------------------------------------------------------------------
  // Host read path
  // --------------------------------------------------------------------------
  always @* begin
    // Only the control port reads back; the other two ports are write only.
    io_claim_next = access && (hit_sc || (io_wr && (hit_rtc || hit_fr)));
    io_rdata_next = (io_rd && hit_sc) ? sc_read_word : 8'h00;
    cfg_rdata_next = (cfg_index == `SPN_CFG_RTC_SHADOW) ? {1'b0, rtc_index_reg[6:0]} : 8'h00;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      io_rdata <= 8'h00;
      io_claim <= 1'b0;
      cfg_rdata <= 8'h00;
    end else begin
      io_rdata <= io_rdata_next;
      io_claim <= io_claim_next;
      cfg_rdata <= cfg_rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Speaker and NMI
  // --------------------------------------------------------------------------
  always @* begin
    second_timer_gate_bit_next = sys_ctrl_reg[`SPN_SC_SECOND_TIMER_GATE_BIT];
    // The speaker is a registered level, so it trails a timer edge by one clock.
    speaker_out_next = ~(sys_ctrl_reg[`SPN_SC_SPKR_DATA] & t2_status);
    // The mask sits after the latches, so a masked error is still seen once unmasked.
    nmi_out_next = ~rtc_index_reg[`SPN_RTC_NMI_MASK] & nmi_sources;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      second_timer_gate_bit <= 1'b0;
      speaker_out <= 1'b1;
      nmi_out <= 1'b0;
    end else begin
      second_timer_gate_bit <= second_timer_gate_bit_next;
      speaker_out <= speaker_out_next;
      nmi_out <= nmi_out_next;
    end
  end

  // --------------------------------------------------------------------------
  // Fast reset and address line 20 gate
  // --------------------------------------------------------------------------
  always @* begin
    // When redirected, software management logic decides whether the reset happens.
    cpu_reset_pulse_next = fr_rise && !smi_redirect;
    system_management_interrupt_next = fr_rise && smi_redirect;
    address_line_20_gate_next = fast_reset_reg[`SPN_FR_A20_BIT];
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_reset_pulse <= 1'b0;
      system_management_interrupt <= 1'b0;
      address_line_20_gate <= 1'b0;
    end else begin
      cpu_reset_pulse <= cpu_reset_pulse_next;
      system_management_interrupt <= system_management_interrupt_next;
      address_line_20_gate <= address_line_20_gate_next;
    end
  end

  // --------------------------------------------------------------------------
  // IDE selects and peripheral events
  // --------------------------------------------------------------------------
  always @* begin
    // The strobes go out one cycle after the access, in step with the read data.
    ide_task_file_select_n_next = select_n(access, tf_hit);
    ide_control_block_select_n_next = select_n(access, cb_hit);
    ide_start_next = access && start_hit;
    periph_event_next = access ? periph_hit : 5'h00;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ide_task_file_select_n <= 1'b1;
      ide_control_block_select_n <= 1'b1;
      ide_start <= 1'b0;
      periph_event <= 5'h00;
    end else begin
      ide_task_file_select_n <= ide_task_file_select_n_next;
      ide_control_block_select_n <= ide_control_block_select_n_next;
      ide_start <= ide_start_next;
      periph_event <= periph_event_next;
    end
  end

endmodule // spn_port_decode

// ### dv/spn_host_model.sv
`timescale 1ns/10ps
module spn_host_model (
  // Clock
  input wire clk,
  // Host I/O access
  output reg [15:0] io_addr = 16'h0000,
  output reg [7:0] io_wdata = 8'h00,
  output reg io_rd = 1'b0,
  output reg io_wr = 1'b0
);
  // Released lines show the inverse of the last value, so a stale address can never pass for a held one.
  task automatic acc(input logic rd, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_rd <= rd;
    io_wr <= wr;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    #1;
  endtask
endmodule // spn_host_model

// ### dv/spn_port_decode_assertions.sv
`timescale 1ns/10ps
module spn_port_decode_assertions (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Watched ports
  input wire [15:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_rd,
  input wire io_wr,
  input wire [7:0] io_rdata,
  input wire io_claim,
  input wire timer2_out,
  input wire second_timer_gate_bit,
  input wire speaker_out,
  input wire smi_redirect,
  input wire cpu_reset_pulse,
  input wire system_management_interrupt,
  input wire address_line_20_gate,
  input wire [3:0] ide_range_en,
  input wire fast_ide_pri_en,
  input wire fast_ide_sec_en,
  input wire ide_task_file_select_n,
  input wire ide_start,
  input wire [4:0] periph_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire io_any = io_rd | io_wr;
  // The speaker is registered from registers, so its level lands one edge after the register update.
  property p_speaker;
    io_wr && io_addr == 16'h0061 && !io_wdata[1] |=> ##1 speaker_out;
  endproperty
  a_speaker: assert property (p_speaker) else $error("speaker not high");
  // The gate copy trails the control register by one edge, so it is taken unshifted here.
  property p_read;
    io_rd && io_addr == 16'h0061 |=> io_claim && io_rdata[5] == ($past(timer2_out) | !second_timer_gate_bit);
  endproperty
  a_read: assert property (p_read) else $error("timer status read");
  property p_reset;
    cpu_reset_pulse |-> $past(io_wr && io_addr == 16'h0092 && io_wdata[0] && !smi_redirect);
  endproperty
  a_reset: assert property (p_reset) else $error("stray cpu reset");
  property p_redirect;
    system_management_interrupt |-> $past(io_wr && io_addr == 16'h0092 && io_wdata[0] && smi_redirect);
  endproperty
  a_redirect: assert property (p_redirect) else $error("stray redirect");
  property p_a20;
    io_wr && io_addr == 16'h0092 |=> ##1 address_line_20_gate == $past(io_wdata[1], 2);
  endproperty
  a_a20: assert property (p_a20) else $error("gate bit");
  property p_start;
    ide_start |-> $past(io_any && (io_addr == 16'h01F0 && fast_ide_pri_en || io_addr == 16'h0170 && fast_ide_sec_en));
  endproperty
  a_start: assert property (p_start) else $error("stray ide start");
  property p_task_file;
    io_any && io_addr[15:3] == 13'h003E && ide_range_en[0] |=> !ide_task_file_select_n;
  endproperty
  a_task_file: assert property (p_task_file) else $error("task file select");
  property p_keyboard;
    io_any && (io_addr == 16'h0060 || io_addr == 16'h0064) |=> periph_event[0] && !io_claim;
  endproperty
  a_keyboard: assert property (p_keyboard) else $error("keyboard event");
endmodule // spn_port_decode_assertions

bind spn_port_decode spn_port_decode_assertions spn_port_decode_assertions_inst (.clk, .reset, .io_addr, .io_wdata,
  .io_rd, .io_wr, .io_rdata, .io_claim, .timer2_out, .second_timer_gate_bit, .speaker_out, .smi_redirect,
  .cpu_reset_pulse, .system_management_interrupt, .address_line_20_gate, .ide_range_en, .fast_ide_pri_en,
  .fast_ide_sec_en, .ide_task_file_select_n, .ide_start, .periph_event);

// ### dv/tb_spn_port_decode.sv
`timescale 1ns/10ps
module tb_spn_port_decode;
  localparam logic [23:0] FR_SEQ = 24'h6A_C648;
  logic clk = 0, reset = 1, timer2_out = 0, refresh_toggle = 0, channel_check_n = 1, parity_error = 0;
  logic nmi_ext = 0, smi_redirect = 0, fast_ide_pri_en = 1, fast_ide_sec_en = 1, st;
  logic [1:0] prev;
  logic [3:0] ide_range_en = 4'hF;
  logic [7:0] cfg_index = 8'h00, ex;
  logic [2:0] fv;
  wire [15:0] io_addr;
  wire [7:0] io_wdata, io_rdata, cfg_rdata;
  wire io_rd, io_wr, io_claim, second_timer_gate_bit, speaker_out, nmi_out, cpu_reset_pulse, ide_start;
  wire system_management_interrupt, address_line_20_gate, ide_task_file_select_n, ide_control_block_select_n;
  wire [4:0] periph_event;
  int errors = 0, total_checks = 0, cyc = 0;
  logic [15:0] pa [16] = '{16'h01F0, 16'h01F7, 16'h03F6, 16'h0170, 16'h0377, 16'h05F0, 16'h07F7, 16'h0570,
    16'h0776, 16'h0060, 16'h0064, 16'h02F8, 16'h0378, 16'h03F0, 16'h03C0, 16'h03F8};
  logic [7:0] pe [16] = '{8'h60, 8'h40, 8'h80, 8'h60, 8'h80, 8'h40, 8'h80, 8'h40,
    8'h80, 8'hC1, 8'hC1, 8'hC2, 8'hC4, 8'hC8, 8'hD0, 8'hC2};
  always #2 clk = ~clk;
  spn_host_model spn_host_model_inst (.clk, .io_addr, .io_wdata, .io_rd, .io_wr);
  spn_port_decode spn_port_decode_inst (.clk, .reset, .io_addr, .io_wdata, .io_rd, .io_wr, .io_rdata, .io_claim,
    .cfg_index, .cfg_rdata, .timer2_out, .refresh_toggle, .channel_check_n, .parity_error, .nmi_ext,
    .second_timer_gate_bit, .speaker_out, .nmi_out, .smi_redirect, .cpu_reset_pulse, .system_management_interrupt,
    .address_line_20_gate, .ide_range_en, .fast_ide_pri_en, .fast_ide_sec_en, .ide_task_file_select_n,
    .ide_control_block_select_n, .ide_start, .periph_event);
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    spn_host_model_inst.acc(1'b0, 1'b1, a, d);
  endtask
  task rd(input logic [15:0] a);
    spn_host_model_inst.acc(1'b1, 1'b0, a, 8'h00);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 0;
    #1;
    chk({3'b000, speaker_out, ide_task_file_select_n, ide_control_block_select_n, nmi_out, io_claim}, 8'h1C);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      timer2_out <= i[0];
      refresh_toggle <= i[0];
      wr(16'h0061, {6'h00, i[2:1]});
      tick;
      st = i[0] | ~i[1];
      chk({6'h00, second_timer_gate_bit, speaker_out}, {6'h00, i[1], ~(i[2] & st)});
      rd(16'h0061);
      chk(io_rdata, {2'b00, st, i[0], 2'b00, i[2:1]});
      chk({7'h00, io_claim}, 8'h01);
    end
    @(posedge clk);
    channel_check_n <= 0;
    parity_error <= 1;
    @(posedge clk);
    channel_check_n <= 1;
    parity_error <= 0;
    rd(16'h0061);
    chk(io_rdata & 8'hC0, 8'hC0);
    chk({7'h00, nmi_out}, 8'h01);
    wr(16'h0070, 8'hD5);
    tick;
    chk({7'h00, nmi_out}, 8'h00);
    @(posedge clk);
    cfg_index <= 8'h96;
    tick;
    chk(cfg_rdata, 8'h55);
    wr(16'h0070, 8'h00);
    wr(16'h0061, 8'h0C);
    // The latches clear one edge after the write and the NMI one edge after that.
    tick;
    tick;
    chk({7'h00, nmi_out}, 8'h00);
    rd(16'h0061);
    chk(io_rdata & 8'hC0, 8'h00);
    @(posedge clk);
    nmi_ext <= 1;
    tick;
    chk({7'h00, nmi_out}, 8'h01);
    prev = 2'b00;
    for (int i = 0; i < 8; i++) begin
      fv = FR_SEQ[3 * i +: 3];
      @(posedge clk);
      smi_redirect <= fv[2];
      wr(16'h0092, {6'h00, fv[1:0]});
      // The gate follows the stored bit one edge later, so it still shows the previous write here.
      ex = {5'h00, fv[0] & ~prev[0] & ~fv[2], fv[0] & ~prev[0] & fv[2], prev[1]};
      chk({5'h00, cpu_reset_pulse, system_management_interrupt, address_line_20_gate}, ex);
      chk({7'h00, io_claim}, 8'h01);
      prev = fv[1:0];
    end
    for (int i = 0; i < 16; i++) begin
      spn_host_model_inst.acc(i[0], ~i[0], pa[i], 8'h00);
      chk({ide_task_file_select_n, ide_control_block_select_n, ide_start, periph_event}, pe[i]);
      chk({7'h00, io_claim}, 8'h00);
    end
    @(posedge clk);
    fast_ide_pri_en <= 0;
    rd(16'h01F0);
    chk({5'h00, ide_task_file_select_n, ide_control_block_select_n, ide_start}, 8'h02);
    close_out;
  end
endmodule // tb_spn_port_decode
